/* File: inc/mes_pkg.sv */
// Package: register map, field layout and reset values of the monitor-enable bank
package mes_pkg;
  localparam logic [7:0]  ADDR_MON_EN      = 8'h00;
  localparam logic [7:0]  ADDR_SCRATCH     = 8'h04;
  localparam logic [7:0]  ADDR_EVENT_GEN   = 8'h08;
  localparam logic [7:0]  ADDR_EVENT       = 8'h0c;
  localparam logic [31:0] MON_EN_RESET     = 32'h17ff_fffd;
  localparam logic [31:0] MON_EN_WMASK     = 32'h17ff_fffd;
  localparam logic [31:0] SCRATCH_RESET    = 32'h0000_0000;
  localparam logic [31:0] EVENT_RESET      = 32'h0000_0000;
  localparam int          BIT_CAL_TIMEOUT  = 28;
  localparam int          BIT_LOADER_CRC   = 26;
  localparam int          BIT_HOST_CRC     = 25;
  localparam int          BIT_SIG_RELOAD   = 24;
  localparam int          BIT_SIG_FAIL     = 23;
  localparam int          BIT_DUAL_XTAL    = 22;
  localparam int          BIT_XTAL_SWITCH  = 21;
  localparam int          FREQ_LSB         = 9;
  localparam int          FREQ_MSB         = 20;
  localparam int          SHORT_TERM_LSB   = 7;
  localparam int          SHORT_TERM_MSB   = 8;
  localparam int          PPM_ERR_BIT      = 6;
  localparam int          PPM_WARN_BIT     = 5;
  localparam int          LOS_LSB          = 3;
  localparam int          LOS_MSB          = 4;
  localparam int          BIT_PLL_LOCK     = 2;
  localparam int          BIT_SELF_TEST    = 0;
  localparam logic [1:0]  RESP_OKAY        = 2'b00;
  localparam logic [1:0]  RESP_SLVERR      = 2'b10;
endpackage

/* File: hdl/mes_top.sv */
// Monitor-enable and scratch register bank with AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module mes_top (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [31:0] SOURCE_EVENTS,
  input  wire logic        EVENT_CLEAR,
  input  wire logic [31:0] EVENT_CLEAR_MASK,
  output var  logic [31:0] SUMMARY_EVENTS,
  output var  logic        PPM_FAULT,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output var  logic        S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output var  logic        S_AXI_WREADY,
  output var  logic [1:0]  S_AXI_BRESP,
  output var  logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output var  logic        S_AXI_ARREADY,
  output var  logic [31:0] S_AXI_RDATA,
  output var  logic [1:0]  S_AXI_RRESP,
  output var  logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  typedef struct packed {
    logic [31:0] mon_en;
    logic [31:0] scratch;
    logic [31:0] events;
    logic        ppm_fault;
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } mes_state_s;

  mes_state_s st;
  mes_state_s next_st;

  function automatic logic [31:0] mes_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mes_mapped(input logic [7:0] a);
    return a == mes_pkg::ADDR_MON_EN || a == mes_pkg::ADDR_SCRATCH ||
           a == mes_pkg::ADDR_EVENT_GEN || a == mes_pkg::ADDR_EVENT;
  endfunction

  logic [31:0] gated;
  logic [31:0] gen;
  logic        do_write;

  always_comb begin
    next_st = st;
    gen = 32'h0000_0000;
    do_write = st.aw_full && st.w_full && !st.bvalid;
    // Enable bits pass sources through one by one, bit n to event bit n
    gated = SOURCE_EVENTS & st.mon_en;
    gated[mes_pkg::SHORT_TERM_MSB:mes_pkg::SHORT_TERM_LSB] =
      SOURCE_EVENTS[mes_pkg::SHORT_TERM_MSB:mes_pkg::SHORT_TERM_LSB] &
      st.mon_en[mes_pkg::SHORT_TERM_MSB:mes_pkg::SHORT_TERM_LSB];
    gated[mes_pkg::LOS_MSB:mes_pkg::LOS_LSB] = SOURCE_EVENTS[mes_pkg::LOS_MSB:mes_pkg::LOS_LSB] &
      st.mon_en[mes_pkg::LOS_MSB:mes_pkg::LOS_LSB];
    gated[mes_pkg::BIT_PLL_LOCK] = SOURCE_EVENTS[mes_pkg::BIT_PLL_LOCK] &
      st.mon_en[mes_pkg::BIT_PLL_LOCK];
    gated[mes_pkg::BIT_SELF_TEST] = SOURCE_EVENTS[mes_pkg::BIT_SELF_TEST] &
      st.mon_en[mes_pkg::BIT_SELF_TEST];
    // Write channel capture
    if (S_AXI_AWVALID && st.awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && st.wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = S_AXI_WDATA;
      next_st.w_strb = S_AXI_WSTRB;
    end
    if (do_write) begin
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = mes_mapped(st.aw_addr) ? mes_pkg::RESP_OKAY : mes_pkg::RESP_SLVERR;
      case (st.aw_addr)
        mes_pkg::ADDR_MON_EN: begin
          next_st.mon_en = mes_merge(st.mon_en, st.w_data, st.w_strb) &
                           mes_pkg::MON_EN_WMASK;
        end
        mes_pkg::ADDR_SCRATCH: begin
          next_st.scratch = mes_merge(st.scratch, st.w_data, st.w_strb);
        end
        mes_pkg::ADDR_EVENT_GEN: begin
          gen = mes_merge(32'h0000_0000, st.w_data, st.w_strb) & mes_pkg::MON_EN_WMASK;
        end
        default: begin
        end
      endcase
    end
    if (S_AXI_BREADY && st.bvalid) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = !next_st.aw_full && !next_st.bvalid;
    next_st.wready = !next_st.w_full && !next_st.bvalid;
    // Latched events: clear first, then a new set wins; enables never clear
    if (EVENT_CLEAR) begin
      next_st.events = st.events & ~EVENT_CLEAR_MASK;
    end
    next_st.events = next_st.events | gated | gen;
    next_st.ppm_fault =
      (st.events[mes_pkg::PPM_ERR_BIT] && st.mon_en[mes_pkg::PPM_ERR_BIT]) ||
      (st.events[mes_pkg::PPM_WARN_BIT] && st.mon_en[mes_pkg::PPM_WARN_BIT]);
    // Read channel
    if (S_AXI_ARVALID && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = mes_mapped(S_AXI_ARADDR) ? mes_pkg::RESP_OKAY : mes_pkg::RESP_SLVERR;
      case (S_AXI_ARADDR)
        mes_pkg::ADDR_MON_EN:    next_st.rdata = st.mon_en & mes_pkg::MON_EN_WMASK;
        mes_pkg::ADDR_SCRATCH:   next_st.rdata = st.scratch;
        mes_pkg::ADDR_EVENT_GEN: next_st.rdata = 32'h0000_0000;
        mes_pkg::ADDR_EVENT:     next_st.rdata = st.events;
        default:                 next_st.rdata = 32'h0000_0000;
      endcase
    end else if (S_AXI_RREADY && st.rvalid) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st <= '0;
      st.mon_en <= mes_pkg::MON_EN_RESET;
      st.scratch <= mes_pkg::SCRATCH_RESET;
      st.events <= mes_pkg::EVENT_RESET;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign SUMMARY_EVENTS = st.events;
  assign PPM_FAULT = st.ppm_fault;
  assign S_AXI_AWREADY = st.awready;
  assign S_AXI_WREADY = st.wready;
  assign S_AXI_BVALID = st.bvalid;
  assign S_AXI_BRESP = st.bresp;
  assign S_AXI_ARREADY = st.arready;
  assign S_AXI_RVALID = st.rvalid;
  assign S_AXI_RDATA = st.rdata;
  assign S_AXI_RRESP = st.rresp;

endmodule
`default_nettype wire

/* File: tb/mes_props.sv */
// Checker: bus and event assertions for the monitor-enable bank
`timescale 1ns/100ps
`default_nettype none
module mes_props (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic [31:0] SOURCE_EVENTS,
  input wire logic        EVENT_CLEAR,
  input wire logic [31:0] EVENT_CLEAR_MASK,
  input wire logic [31:0] SUMMARY_EVENTS,
  input wire logic        PPM_FAULT,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  property p_sticky;
    1 |-> ($past(SUMMARY_EVENTS) & ~SUMMARY_EVENTS
           & ~({32{$past(EVENT_CLEAR)}} & $past(EVENT_CLEAR_MASK))) == 32'h0;
  endproperty
  a_sticky: assert property (p_sticky) else $error("latched event lost");
  property p_rsum;
    (SUMMARY_EVENTS & 32'he800_0002) == 32'h0;
  endproperty
  a_rsum: assert property (p_rsum) else $error("reserved event set");
  property p_rsvd;
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h00
      |=> (S_AXI_RDATA & 32'he800_0002) == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved enable bit read one");
  property p_gen;
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h08 |=> S_AXI_RDATA == 32'h0;
  endproperty
  a_gen: assert property (p_gen) else $error("generate word read nonzero");
  property p_rlat;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_fault;
    PPM_FAULT |-> $past(SUMMARY_EVENTS[6] | SUMMARY_EVENTS[5]);
  endproperty
  a_fault: assert property (p_fault) else $error("fault without ppm source");
  property p_bhold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule
bind mes_top mes_props chk_u (.CLK(CLK), .RESET(RESET), .SOURCE_EVENTS(SOURCE_EVENTS),
  .EVENT_CLEAR(EVENT_CLEAR), .EVENT_CLEAR_MASK(EVENT_CLEAR_MASK),
  .SUMMARY_EVENTS(SUMMARY_EVENTS), .PPM_FAULT(PPM_FAULT), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY));
`default_nettype wire

/* File: tb/tb_top.sv */
// Testbench: register bus, gating and latching of the monitor-enable bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [31:0] MASK = 32'h17ff_fffd;
  logic CLK = 0, RESET = 1, EVENT_CLEAR = 0, AWVALID = 0, WVALID = 0, BREADY = 0;
  logic ARVALID = 0, RREADY = 0, AWREADY, WREADY, BVALID, ARREADY, RVALID, PPM_FAULT;
  logic [31:0] SOURCE_EVENTS = 0, WDATA = 0, SUMMARY_EVENTS, RDATA, en, s, v;
  logic [7:0]  AWADDR = 0, ARADDR = 0;
  logic [1:0]  BRESP, RRESP;
  logic [33:0] exp_q[$];
  int          bad_count = 0, compares = 0;
  always #5 CLK = ~CLK;
  mes_top dut_u (.CLK(CLK), .RESET(RESET), .SOURCE_EVENTS(SOURCE_EVENTS),
    .EVENT_CLEAR(EVENT_CLEAR), .EVENT_CLEAR_MASK(32'hffff_ffff), .SUMMARY_EVENTS(SUMMARY_EVENTS),
    .PPM_FAULT(PPM_FAULT), .S_AXI_AWADDR(AWADDR), .S_AXI_AWVALID(AWVALID),
    .S_AXI_AWREADY(AWREADY), .S_AXI_WDATA(WDATA), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(WVALID),
    .S_AXI_WREADY(WREADY), .S_AXI_BRESP(BRESP), .S_AXI_BVALID(BVALID), .S_AXI_BREADY(BREADY),
    .S_AXI_ARADDR(ARADDR), .S_AXI_ARVALID(ARVALID), .S_AXI_ARREADY(ARREADY),
    .S_AXI_RDATA(RDATA), .S_AXI_RRESP(RRESP), .S_AXI_RVALID(RVALID), .S_AXI_RREADY(RREADY));
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error bus answer: expected %h seen %h", exp, seen);
    end
  endtask
  // One write (w=1) or read; notes the expected answer first
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
    int n;
    bit ac, wd, done;
    exp_q.push_back({r, w ? 32'h0 : d});
    @(posedge CLK);
    if (w) begin
      AWADDR <= a; WDATA <= d; AWVALID <= 1; WVALID <= 1;
    end else begin
      ARADDR <= a; ARVALID <= 1;
    end
    done = 0;
    for (n = 0; n < 50 && !done; n++) begin
      @(negedge CLK);
      ac = (AWVALID && AWREADY) || (ARVALID && ARREADY);
      wd = WVALID && WREADY;
      done = (BVALID && BREADY) || (RVALID && RREADY);
      @(posedge CLK);
      if (ac) begin
        AWVALID <= 0; ARVALID <= 0;
      end
      if (wd) WVALID <= 0;
      BREADY <= w && n > 1 && !done;
      RREADY <= !w && n > 1 && !done;
    end
    if (!done) begin
      bad_count++;
      stop_test();
    end
  endtask
  task automatic drive(input logic [31:0] src, input logic clr);
    @(posedge CLK);
    SOURCE_EVENTS <= src; EVENT_CLEAR <= clr;
    @(posedge CLK);
    SOURCE_EVENTS <= 0; EVENT_CLEAR <= 0;
  endtask
  always @(posedge CLK)
    if ((BVALID && BREADY) || (RVALID && RREADY))
      chk(BVALID ? {BRESP, 32'h0} : {RRESP, RDATA}, exp_q.pop_front());
  initial begin
    void'($urandom(54928));
    repeat (6) @(posedge CLK);
    RESET <= 0;
    xfer(0, 8'h00, MASK, 0); xfer(0, 8'h04, 0, 0); xfer(0, 8'h0c, 0, 0);
    xfer(1, 8'h00, 32'hffff_ffff, 0); xfer(0, 8'h00, MASK, 0);
    for (int i = 0; i < 4; i++) begin
      v = $urandom; xfer(1, 8'h04, v, 0); xfer(0, 8'h04, v, 0);
    end
    xfer(1, 8'h10, v, 2'b10); xfer(0, 8'h10, 0, 2'b10);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      en = $urandom; s = $urandom; drive(0, 1);
      en[8:7] = {2{en[7]}};
      xfer(1, 8'h00, en, 0); drive(s, 0); xfer(0, 8'h0c, s & en & MASK, 0);
      chk({33'h0, PPM_FAULT}, {33'h0, (s[6] & en[6]) | (s[5] & en[5])});
      xfer(1, 8'h00, 0, 0); drive(~s, 0); xfer(0, 8'h0c, s & en & MASK, 0);
      chk({33'h0, PPM_FAULT}, 34'h0);
    end
    $display("test gating done");
    drive(0, 1); v = $urandom;
    xfer(1, 8'h08, v, 0); xfer(0, 8'h0c, v & MASK, 0); xfer(0, 8'h08, 0, 0);
    $display("test generate done");
    stop_test();
  end
endmodule
`default_nettype wire
